// ### rtl/dlb_pkg.sv
// Package for the deterministic latency bit-slip block.
// Assumes a single clk_sys domain; shared by all rtl files.
package dlb_pkg;
  // ----------------------------------------
  // Wishbone register map
  // ----------------------------------------
  localparam logic [7:0]  DLB_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  DLB_ADDR_STATUS = 8'h04;
  localparam logic [7:0]  DLB_ADDR_SLIP   = 8'h08;
  localparam logic [31:0] DLB_CTRL_RESET  = 32'h0000_0000;

  // CTRL field positions
  localparam int DLB_CTRL_DETLAT  = 0;
  localparam int DLB_CTRL_TXREG   = 1;
  localparam int DLB_CTRL_WIDE    = 2;
  localparam int DLB_CTRL_CODEC   = 3;
  localparam int DLB_CTRL_FBEN    = 4;
  localparam int DLB_CTRL_SLIPREQ = 8;
  localparam int DLB_CTRL_W       = 5;

  // ----------------------------------------
  // Datapath figures
  // ----------------------------------------
  localparam int          DLB_DW          = 20;
  localparam int          DLB_SW          = 5;
  localparam logic [4:0]  DLB_SLIP_MAX_N  = 5'h09;
  localparam logic [4:0]  DLB_SLIP_MAX_W  = 5'h13;
  localparam logic [4:0]  DLB_WIDE_BASE   = 5'h13;
  localparam logic [4:0]  DLB_SLIP_ZERO   = 5'h00;

  typedef enum logic [1:0] {
    DLB_RD_CTRL,
    DLB_RD_STATUS,
    DLB_RD_SLIP,
    DLB_RD_NONE
  } dlb_rsel_t;
endpackage

// ### rtl/dlb_shift.sv
// Bit-slip barrel stage used by both directions.
// Assumes shift amount already decoded to a raw bit count.
`timescale 1ns/1ps
module dlb_shift
  import dlb_pkg::*;
(
  input  wire logic [DLB_DW-1:0] cur_word,
  input  wire logic [DLB_DW-1:0] prev_word,
  input  wire logic [DLB_SW-1:0] amount,
  input  wire logic              wide,
  output logic      [DLB_DW-1:0] out_word
);
  logic [2*DLB_DW-1:0] joined;
  logic [2*DLB_DW-1:0] shifted;

  // Narrow mode uses only the low 10 bits of each word
  always_comb begin
    if (wide) begin
      joined = {cur_word, prev_word};
    end else begin
      joined = {20'h00000, cur_word[9:0], prev_word[9:0]};
    end
    shifted  = joined >> (wide ? (DLB_DW - 32'(amount)) : (10 - 32'(amount)));
    out_word = wide ? shifted[DLB_DW-1:0] : {10'h000, shifted[9:0]};
  end
endmodule // dlb_shift

// ### rtl/dlb_top.sv
// Deterministic latency bit-slip channel block with Wishbone control.
// Assumes all data ports are on clk_sys; fabric loops slip back.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module dlb_top
  import dlb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [DLB_DW-1:0] tx_word,
  output logic      [DLB_DW-1:0] tx_ser_word,
  input  wire logic [DLB_SW-1:0] tx_slip_sel,
  input  wire logic [DLB_DW-1:0] rx_ser_word,
  input  wire logic              rx_slip_req,
  output logic      [DLB_DW-1:0] rx_word,
  output logic      [DLB_SW-1:0] rx_slip_count,
  output logic                   tx_slip_en,
  output logic                   rx_fifo_reg_mode,
  output logic                   tx_fifo_reg_mode,
  output logic                   codec_bypass,
  output logic                   clock_multiplier_pll_fb_en
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Encode raw slip bits for the port, and decode back
  function automatic logic [4:0] dlb_code(input logic [4:0] bits, input logic wide);
    dlb_code = wide ? 5'(DLB_WIDE_BASE - bits) : bits;
  endfunction

  function automatic logic [4:0] dlb_clip(input logic [4:0] bits, input logic wide);
    logic [4:0] lim;
    lim      = wide ? DLB_SLIP_MAX_W : DLB_SLIP_MAX_N;
    dlb_clip = (bits > lim) ? lim : bits;
  endfunction

  // ----------------------------------------
  // Control register and bus slave
  // ----------------------------------------
  logic [DLB_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic                  ack_r, ack_nxt;
  logic [31:0]           rdat_r, rdat_nxt;
  logic                  width_err_r, width_err_nxt;
  logic                  sw_slip_r, sw_slip_nxt;
  logic                  bus_wr;
  logic                  detlat, wide_cfg;

  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign detlat   = ctrl_r[DLB_CTRL_DETLAT];
  assign wide_cfg = ctrl_r[DLB_CTRL_WIDE] && detlat;

  always_comb begin
    ctrl_nxt      = ctrl_r;
    width_err_nxt = width_err_r;
    sw_slip_nxt   = 1'b0;
    ack_nxt       = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt      = 32'h0000_0000;
    if (bus_wr && wb_adr_i == DLB_ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_nxt = wb_dat_i[DLB_CTRL_W-1:0];
        // Wide width refused outside deterministic mode
        if (wb_dat_i[DLB_CTRL_WIDE] && !wb_dat_i[DLB_CTRL_DETLAT]) begin
          ctrl_nxt[DLB_CTRL_WIDE] = 1'b0;
          width_err_nxt           = 1'b1;
        end
      end
      if (wb_sel_i[1]) begin
        sw_slip_nxt = wb_dat_i[DLB_CTRL_SLIPREQ];
      end
    end
    if (bus_wr && wb_adr_i == DLB_ADDR_STATUS && wb_sel_i[0] && wb_dat_i[0]) begin
      width_err_nxt = 1'b0;
    end
    case (wb_adr_i)
      DLB_ADDR_CTRL:   rdat_nxt = {27'h0, ctrl_r};
      DLB_ADDR_STATUS: rdat_nxt = {31'h0, width_err_r};
      DLB_ADDR_SLIP:   rdat_nxt = {19'h0, tx_slip_sel, 3'h0, rx_slip_count};
      default:         rdat_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r      <= DLB_CTRL_RESET[DLB_CTRL_W-1:0];
      ack_r       <= 1'b0;
      rdat_r      <= 32'h0000_0000;
      width_err_r <= 1'b0;
      sw_slip_r   <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      ack_r       <= ack_nxt;
      rdat_r      <= rdat_nxt;
      width_err_r <= width_err_nxt;
      sw_slip_r   <= sw_slip_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  logic [4:0] mode_r, mode_nxt;

  always_comb begin
    mode_nxt[0] = detlat;
    mode_nxt[1] = detlat;
    mode_nxt[2] = detlat && ctrl_r[DLB_CTRL_TXREG];
    mode_nxt[3] = detlat && !ctrl_r[DLB_CTRL_CODEC];
    mode_nxt[4] = detlat && ctrl_r[DLB_CTRL_FBEN];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= 5'h00;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign tx_slip_en                 = mode_r[0];
  assign rx_fifo_reg_mode           = mode_r[1];
  assign tx_fifo_reg_mode           = mode_r[2];
  assign codec_bypass               = mode_r[3];
  assign clock_multiplier_pll_fb_en = mode_r[4];

  // ----------------------------------------
  // Receive word aligner
  // ----------------------------------------
  logic [DLB_DW-1:0] rx_s1_r, rx_s2_r, rx_prev_r, rx_prev_nxt;
  logic              req_s1_r, req_s2_r, req_d_r;
  logic [4:0]        rx_bits_r, rx_bits_nxt;
  logic [DLB_DW-1:0] rx_al, rx_word_r, rx_word_nxt;
  logic [4:0]        rx_cnt_r, rx_cnt_nxt;
  logic              slip_ev;

  assign slip_ev = (req_s2_r && !req_d_r) || sw_slip_r;

  always_comb begin
    rx_prev_nxt = rx_s2_r;
    rx_bits_nxt = dlb_clip(rx_bits_r, wide_cfg);
    if (slip_ev) begin
      rx_bits_nxt = (rx_bits_r >= (wide_cfg ? DLB_SLIP_MAX_W : DLB_SLIP_MAX_N))
                    ? DLB_SLIP_ZERO : 5'(rx_bits_r + 5'h01);
    end
    rx_cnt_nxt  = dlb_code(rx_bits_r, wide_cfg);
    rx_word_nxt = rx_al;
  end

  dlb_shift u_rx_shift (
    .cur_word  (rx_s2_r),
    .prev_word (rx_prev_r),
    .amount    (rx_bits_r),
    .wide      (wide_cfg),
    .out_word  (rx_al)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_s1_r   <= '0;
      rx_s2_r   <= '0;
      rx_prev_r <= '0;
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_d_r   <= 1'b0;
      rx_bits_r <= DLB_SLIP_ZERO;
      rx_cnt_r  <= DLB_SLIP_ZERO;
      rx_word_r <= '0;
    end else begin
      rx_s1_r   <= rx_ser_word;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= rx_prev_nxt;
      req_s1_r  <= rx_slip_req;
      req_s2_r  <= req_s1_r;
      req_d_r   <= req_s2_r;
      rx_bits_r <= rx_bits_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_word_r <= rx_word_nxt;
    end
  end

  assign rx_slip_count = rx_cnt_r;
  assign rx_word       = rx_word_r;

  // ----------------------------------------
  // Transmit bit-slip stage
  // ----------------------------------------
  logic [DLB_DW-1:0] tx_fifo_r, tx_fifo_nxt, tx_prev_r, tx_sl, tx_out_r, tx_out_nxt;
  logic [4:0]        tx_bits;

  // Same encoding as receive: undo the wide offset
  assign tx_bits = dlb_clip(dlb_code(tx_slip_sel, wide_cfg), wide_cfg);

  dlb_shift u_tx_shift (
    .cur_word  (tx_fifo_r),
    .prev_word (tx_prev_r),
    .amount    (tx_slip_en ? tx_bits : DLB_SLIP_ZERO),
    .wide      (wide_cfg),
    .out_word  (tx_sl)
  );

  always_comb begin
    tx_fifo_nxt = tx_word;
    tx_out_nxt  = tx_sl;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_fifo_r <= '0;
      tx_prev_r <= '0;
      tx_out_r  <= '0;
    end else begin
      tx_fifo_r <= tx_fifo_nxt;
      tx_prev_r <= tx_fifo_r;
      tx_out_r  <= tx_out_nxt;
    end
  end

  assign tx_ser_word = tx_out_r;
endmodule // dlb_top

// ### tb/dlb_asserts.sv
// Port checker for dlb_top.
// Assumes it is bound onto dlb_top on clk_sys.
`timescale 1ns/1ps
module dlb_asserts
  import dlb_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [DLB_SW-1:0] rx_slip_count,
  input wire logic              tx_slip_en,
  input wire logic              rx_fifo_reg_mode,
  input wire logic              tx_fifo_reg_mode,
  input wire logic              codec_bypass,
  input wire logic              clock_multiplier_pll_fb_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_mode_pair:
    assert property (tx_slip_en == rx_fifo_reg_mode) else $error("mode pair split");
  a_txreg_det:
    assert property (tx_fifo_reg_mode |-> tx_slip_en) else $error("tx reg mode outside det");
  a_codec_det:
    assert property (codec_bypass |-> tx_slip_en) else $error("bypass outside det");
  a_fb_det:
    assert property (clock_multiplier_pll_fb_en |-> tx_slip_en) else $error("feedback outside det");
  a_slip_range:
    assert property (rx_slip_count <= DLB_SLIP_MAX_W) else $error("slip code too large");
  a_narrow_code:
    assert property (!tx_slip_en [*5] |-> rx_slip_count <= DLB_SLIP_MAX_N) else $error("narrow code too large");
  a_ack_follows:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_quiet:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
endmodule // dlb_asserts

bind dlb_top dlb_asserts dlb_asserts_inst (
  .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_slip_count(rx_slip_count), .tx_slip_en(tx_slip_en), .rx_fifo_reg_mode(rx_fifo_reg_mode),
  .tx_fifo_reg_mode(tx_fifo_reg_mode), .codec_bypass(codec_bypass),
  .clock_multiplier_pll_fb_en(clock_multiplier_pll_fb_en));

// ### tb/dlb_fabric.sv
// Fabric-side model: loops slip code back, presents tx words.
// Assumes the same clk_sys as dlb_top.
`timescale 1ns/1ps
module dlb_fabric
  import dlb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [DLB_SW-1:0] rx_slip_count,
  input  wire logic [DLB_DW-1:0] word_in,
  output logic      [DLB_SW-1:0] tx_slip_sel,
  output logic      [DLB_DW-1:0] tx_word
);
  initial begin
    tx_slip_sel = '0;
    tx_word = '0;
  end
  always @(posedge clk_sys) begin
    tx_slip_sel <= rx_slip_count;
    tx_word     <= word_in;
  end
endmodule // dlb_fabric

// ### tb/tb_deterministic_latency_bitslip.sv
// Bench for dlb_top: bus, modes, slip codes and data.
// Assumes one clk_sys domain and a looping fabric model.
`timescale 1ns/1ps
module tb_deterministic_latency_bitslip
  import dlb_pkg::*;
();
  logic              clk_sys = 1'h0;
  logic              srst = 1'h1;
  logic              wb_req = 1'h0;
  logic              wb_we = 1'h0;
  logic              slip_req = 1'h0;
  logic [7:0]        wb_adr = 8'h00;
  logic [3:0]        wb_sel = 4'hf;
  logic [31:0]       wb_wd = 32'h0;
  logic [31:0]       wb_rd, rd, c;
  logic              wb_ack;
  logic [DLB_DW-1:0] rx_ser = '0, word_in = '0, tx_word, tx_ser, rx_word;
  logic [DLB_SW-1:0] sel, code;
  wire  [4:0]        modes;
  logic [4:0]        corner [4] = '{5'h00, 5'h04, 5'h1f, 5'h0b};
  int                seed = 34, fail_count = 0, samples_checked = 0;

  always #4 clk_sys = ~clk_sys;

  dlb_top dlb_top_inst (
    .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .tx_word(tx_word), .tx_ser_word(tx_ser), .tx_slip_sel(sel), .rx_ser_word(rx_ser),
    .rx_slip_req(slip_req), .rx_word(rx_word), .rx_slip_count(code), .tx_slip_en(modes[0]),
    .rx_fifo_reg_mode(modes[1]), .tx_fifo_reg_mode(modes[2]), .codec_bypass(modes[3]),
    .clock_multiplier_pll_fb_en(modes[4]));
  dlb_fabric dlb_fabric_inst (.clk_sys(clk_sys), .rx_slip_count(code), .word_in(word_in),
    .tx_slip_sel(sel), .tx_word(tx_word));

  function automatic logic [4:0] exp_modes(input logic [31:0] v);
    return {v[0] & v[4], v[0] & ~v[3], v[0] & v[1], v[0], v[0]};
  endfunction
  function automatic logic [4:0] exp_code(input logic w, input int k);
    return w ? DLB_WIDE_BASE - 5'(k % 20) : 5'(k % 10);
  endfunction
  // Word delayed by k bit positions, wrapping within the lane width
  function automatic logic [DLB_DW-1:0] exp_rot(input logic [DLB_DW-1:0] v, input logic w, input int k);
    int                b;
    logic [DLB_DW-1:0] r;
    b = w ? DLB_DW : DLB_DW / 2;
    r = '0;
    for (int i = 0; i < b; i++) r[(i + k) % b] = v[i];
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_wd <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'h1 && n < 50);
    rd = wb_rd;
    if (n >= 50) fail_count++;
    wb_req <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    srst <= 1'h1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic slip_pin();
    slip_req <= 1'h1;
    repeat (3) @(posedge clk_sys);
    slip_req <= 1'h0;
  endtask
  task automatic data_chk(input logic w);
    logic [DLB_DW-1:0] v, m;
    v = DLB_DW'($random(seed));
    m = w ? '1 : DLB_DW'(20'h003ff);
    rx_ser <= v;
    word_in <= v;
    repeat (8) @(posedge clk_sys);
    chk(32'(tx_ser & m), 32'(v & m), "tx word");
    chk(32'(rx_word & m), 32'(v & m), "rx word");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    do_reset();
    bus(1'h0, DLB_ADDR_CTRL, 32'h0);
    chk(rd, DLB_CTRL_RESET, "ctrl reset");
    bus(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h0, "unmapped");
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? {27'h0, corner[i]} : 32'($random(seed)) & 32'h1f;
      bus(1'h1, DLB_ADDR_CTRL, c);
      chk(32'(modes), 32'(exp_modes(c)), "modes");
      bus(1'h0, DLB_ADDR_CTRL, 32'h0);
      chk(rd, {c[31:3], c[2] & c[0], c[1:0]}, "ctrl");
      bus(1'h0, DLB_ADDR_STATUS, 32'h0);
      chk({31'h0, rd[0]}, {31'h0, c[2] & ~c[0]}, "width err");
      wb_sel <= 4'h0;
      bus(1'h1, DLB_ADDR_CTRL, ~c);
      wb_sel <= 4'hf;
      bus(1'h0, DLB_ADDR_CTRL, 32'h0);
      chk(rd, {c[31:3], c[2] & c[0], c[1:0]}, "ctrl lanes");
      bus(1'h1, DLB_ADDR_STATUS, 32'h1);
    end
    for (int w = 0; w < 2; w++) begin
      do_reset();
      c = w ? 32'h5 : 32'h1;
      bus(1'h1, DLB_ADDR_CTRL, c);
      data_chk(w[0]);
      for (int k = 0; k < 22; k++) begin
        chk(32'(code), 32'(exp_code(w[0], k)), "slip code");
        chk(32'(rx_word), 32'(exp_rot(rx_ser, w[0], k)), "rx slip");
        chk(32'(tx_ser), 32'(exp_rot(word_in, w[0], k)), "tx slip");
        bus(1'h0, DLB_ADDR_SLIP, 32'h0);
        chk(rd, {19'h0, exp_code(w[0], k), 3'h0, exp_code(w[0], k)}, "slip reg");
        if (k[0])
          bus(1'h1, DLB_ADDR_CTRL, c | 32'h100);
        else
          slip_pin();
        repeat (8) @(posedge clk_sys);
      end
    end
    give_verdict();
  end
endmodule // tb_deterministic_latency_bitslip
